// ===== rtl/acisc_regs.svh
/*
 converter control register offsets, field positions, reset values, timing.
 assumes apb with 32-bit data, one register per aligned word.
*/
`ifndef ACISC_REGS_SVH
`define ACISC_REGS_SVH
`define ACISC_CTRL_OFF      12'h000
`define ACISC_ACCUM_OFF     12'h004
`define ACISC_REFCFG_OFF    12'h008
`define ACISC_DELAY_OFF     12'h00c
`define ACISC_WINMODE_OFF   12'h010
`define ACISC_SAMPLE_LENGTH_OFF   12'h014
`define ACISC_INSEL_OFF     12'h018
`define ACISC_COMMAND_OFF   12'h020
`define ACISC_EVCTRL_OFF    12'h024
`define ACISC_INTEN_OFF     12'h028
`define ACISC_INTFLAG_OFF   12'h02c
`define ACISC_RESULT_OFF    12'h040
`define ACISC_WINLO_OFF     12'h048
`define ACISC_WINHI_OFF     12'h050
`define ACISC_STATUS_OFF    12'h058
`define ACISC_CTRL_RUNSTBY  7
`define ACISC_CTRL_RESSEL   2
`define ACISC_CTRL_CONT     1
`define ACISC_CTRL_ENABLE   0
`define ACISC_FLAG_RESULT_READY_FLAG   0
`define ACISC_FLAG_WIN      1
`define ACISC_VEC_RESULT_READY_FLAG    8'h00
`define ACISC_VEC_WIN       8'h02
`define ACISC_TEMP_CHANNEL  5'h1e
`define ACISC_CONV_CYCLES   13
`define ACISC_SAMPLE_AT     2
`define ACISC_INITIAL_DELAY_UNIT  16
`define ACISC_RESET_VALUE   8'h00
`endif

// ===== rtl/acisc_pkg.sv
/*
 types shared by the converter control block.
 assumes the offsets header is included where numbers are needed.
*/
package acisc_pkg;
    typedef enum logic [2:0] {
        ACISC_WIN_OFF     = 3'b000,
        ACISC_WIN_BELOW   = 3'b001,
        ACISC_WIN_ABOVE   = 3'b010,
        ACISC_WIN_INSIDE  = 3'b011,
        ACISC_WIN_OUTSIDE = 3'b100
    } acisc_winmode_type;
    typedef enum logic [1:0] {
        ACISC_IDLE  = 2'b00,
        ACISC_DELAY = 2'b01,
        ACISC_CONV  = 2'b10
    } acisc_state_type;
endpackage

// ===== rtl/acisc_window.sv
/*
 window comparator over a final result.
 assumes result and thresholds are unsigned and stable when checked.
*/
module acisc_window
    import acisc_pkg::*;
(
    input  wire logic              pclk,      // peripheral clock
    input  wire logic              presetn,   // async reset, low
    input  wire logic              check,     // final result valid
    input  wire acisc_pkg::acisc_winmode_type mode, // condition
    input  wire logic [15:0]       result,    // accumulated result
    input  wire logic [15:0]       lo_thr,    // low threshold
    input  wire logic [15:0]       hi_thr,    // high threshold
    output logic                   hit        // one-cycle match pulse
);
    logic match;
    always_comb begin
        case (mode)
            ACISC_WIN_BELOW:   match = result < lo_thr;
            ACISC_WIN_ABOVE:   match = result > hi_thr;
            ACISC_WIN_INSIDE:  match = (result > lo_thr) && (result < hi_thr);
            ACISC_WIN_OUTSIDE: match = (result < lo_thr) || (result > hi_thr);
            default:           match = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit <= 1'b0;
        end else begin
            hit <= check && match && (mode != ACISC_WIN_OFF);
        end
    end
    a_win_below: assert property (@(posedge pclk) disable iff (!presetn)
        check && mode == ACISC_WIN_BELOW && result < lo_thr |=> hit)
        else $error("below match missed");
    a_win_off: assert property (@(posedge pclk) disable iff (!presetn)
        mode == ACISC_WIN_OFF |=> !hit)
        else $error("window hit while off");
endmodule

// ===== rtl/acisc_ctrl.sv
/*
 converter control: apb registers, prescaled conversion sequencer,
 accumulation, window check, interrupt flags, sleep handling, touch hand-over.
 assumes an analog core that returns a 10-bit sample on request, and a
 sleep controller that gives standby and power-down as levels.
*/
`include "acisc_regs.svh"
module acisc_ctrl
    import acisc_pkg::*;
#(
    parameter int PRESC_W = 3                // prescaler field width
)(
    input  wire logic        pclk,           // peripheral clock
    input  wire logic        presetn,        // async reset, low
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic        event_in,       // routed event level
    input  wire logic        touch_enable,   // touch controller owns unit
    input  wire logic        touch_start,    // touch start request
    input  wire logic [4:0]  touch_channel,  // touch input select
    input  wire logic        standby,        // standby sleep level
    input  wire logic        power_down,     // power-down sleep level
    output logic             sample_req,     // analog sample strobe
    input  wire logic [9:0]  sample_data,    // analog sample value
    output logic      [4:0]  channel_sel,    // analog input select
    output logic             temp_sensor_on, // temperature sensor power
    output logic             clock_request,  // peripheral clock request
    output logic             irq_result_ready_flag,     // result ready request
    output logic             irq_window,     // window request
    output logic             touch_done      // touch conversion complete
);
    acisc_state_type state_ff, nxt_state;
    logic [7:0]  ctrl_ff;
    logic [2:0]  accnum_ff;
    logic [7:0]  refcfg_ff;
    logic [2:0]  initial_delay_ff;
    logic [3:0]  sampdly_ff;
    logic [2:0]  winmode_ff;
    logic [4:0]  sample_length_ff;
    logic [4:0]  insel_ff;
    logic        evstart_ff;
    logic [1:0]  inten_ff;
    logic [1:0]  flag_ff;
    logic        start_ff;
    logic        ev_prev_ff;
    logic [15:0] result_ff;
    logic [15:0] acc_ff;
    logic [15:0] winlo_ff;
    logic [15:0] winhi_ff;
    logic        invalid_ff;
    logic        halted_ff;
    logic        sb_prev_ff;
    logic        need_dly_ff;
    logic [7:0]  presc_ff;
    logic [7:0]  cyc_ff;
    logic [6:0]  nsamp_ff;
    logic [7:0]  dly_ff;
    logic        done_ff;
    logic        wr_en, rd_en, clk_tick, ev_edge, active, run_ok;
    logic        samp_end, conv_last, final_done, win_hit, rd_result;
    logic [7:0]  presc_div, conv_len;
    logic [6:0]  samp_total;
    logic [9:0]  sample_eff;
    logic [31:0] nxt_prdata;
    // apb handshake: zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign rd_result = rd_en && paddr == `ACISC_RESULT_OFF;
    assign channel_sel = touch_enable ? touch_channel : insel_ff;
    assign temp_sensor_on = channel_sel == `ACISC_TEMP_CHANNEL;
    // running conversion not cut by standby
    assign run_ok = ctrl_ff[`ACISC_CTRL_ENABLE] && !power_down &&
                    (!standby || ctrl_ff[`ACISC_CTRL_RUNSTBY]);
    assign ev_edge = event_in && !ev_prev_ff;
    // prescaler divides by 2 to the power of field plus one
    assign presc_div = 8'(2 << refcfg_ff[PRESC_W-1:0]);
    assign clk_tick  = presc_ff == presc_div - 8'h01;
    // 13 cycles plus sample delay and length
    assign conv_len = 8'(`ACISC_CONV_CYCLES) + {4'h0, sampdly_ff} +
                      {3'h0, sample_length_ff};
    assign conv_last = clk_tick && cyc_ff == conv_len - 8'h01;
    assign samp_total = 7'(1) << accnum_ff;
    assign samp_end   = state_ff == ACISC_CONV && conv_last && !power_down;
    // only the last accumulated sample completes
    assign final_done = samp_end && nsamp_ff == samp_total - 7'h01;
    assign active = state_ff != ACISC_IDLE;
    assign clock_request = active || start_ff;
    // 8-bit mode drops two low bits
    assign sample_eff = ctrl_ff[`ACISC_CTRL_RESSEL] ?
                        {2'b00, sample_data[9:2]} : sample_data;
    assign sample_req = state_ff == ACISC_CONV && clk_tick &&
                        cyc_ff == 8'(`ACISC_SAMPLE_AT);
    assign irq_result_ready_flag = flag_ff[`ACISC_FLAG_RESULT_READY_FLAG] &&
                        inten_ff[`ACISC_FLAG_RESULT_READY_FLAG];
    assign irq_window = flag_ff[`ACISC_FLAG_WIN] && inten_ff[`ACISC_FLAG_WIN];
    assign touch_done = done_ff && touch_enable;
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= `ACISC_RESET_VALUE;
            accnum_ff  <= 3'h0;
            refcfg_ff  <= `ACISC_RESET_VALUE;
            initial_delay_ff <= 3'h0;
            sampdly_ff <= 4'h0;
            winmode_ff <= 3'h0;
            sample_length_ff <= 5'h00;
            insel_ff   <= 5'h00;
            evstart_ff <= 1'b0;
            inten_ff   <= 2'b00;
            winlo_ff   <= 16'h0000;
            winhi_ff   <= 16'h0000;
        end else if (wr_en) begin
            case (paddr)
                `ACISC_CTRL_OFF:    ctrl_ff    <= pwdata[7:0] & 8'h87;
                `ACISC_ACCUM_OFF:   accnum_ff  <= pwdata[2:0];
                `ACISC_REFCFG_OFF:  refcfg_ff  <= pwdata[7:0] & 8'h77;
                `ACISC_DELAY_OFF: begin
                    initial_delay_ff <= pwdata[7:5];
                    sampdly_ff <= pwdata[3:0];
                end
                `ACISC_WINMODE_OFF: winmode_ff <= pwdata[2:0];
                `ACISC_SAMPLE_LENGTH_OFF: sample_length_ff <= pwdata[4:0];
                `ACISC_INSEL_OFF:   insel_ff   <= pwdata[4:0];
                `ACISC_EVCTRL_OFF:  evstart_ff <= pwdata[0];
                `ACISC_INTEN_OFF:   inten_ff   <= pwdata[1:0];
                `ACISC_WINLO_OFF:   winlo_ff   <= pwdata[15:0];
                `ACISC_WINHI_OFF:   winhi_ff   <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end
    // start bit from software, event or touch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff   <= 1'b0;
            ev_prev_ff <= 1'b0;
        end else begin
            ev_prev_ff <= event_in;
            if (final_done && !(ctrl_ff[`ACISC_CTRL_CONT] && !touch_enable))
            begin
                start_ff <= 1'b0;
            end else if (touch_enable) begin
                if (touch_start) begin
                    start_ff <= 1'b1;
                end
            end else if (ev_edge && evstart_ff &&
                         ctrl_ff[`ACISC_CTRL_ENABLE]) begin
                start_ff <= 1'b1;
            end else if (wr_en && paddr == `ACISC_COMMAND_OFF && pwdata[0])
            begin
                start_ff <= 1'b1;
            end else if (!ctrl_ff[`ACISC_CTRL_ENABLE]) begin
                start_ff <= 1'b0;
            end
        end
    end
    // first conversion after standby entry waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sb_prev_ff  <= 1'b0;
            need_dly_ff <= 1'b0;
        end else begin
            sb_prev_ff <= standby;
            if (standby && !sb_prev_ff && initial_delay_ff != 3'h0) begin
                need_dly_ff <= 1'b1;
            end else if (state_ff == ACISC_DELAY) begin
                need_dly_ff <= 1'b0;
            end
        end
    end
    // sequencer state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ACISC_IDLE: begin
                if (start_ff && run_ok) begin
                    nxt_state = need_dly_ff ? ACISC_DELAY : ACISC_CONV;
                end
            end
            ACISC_DELAY: begin
                if (clk_tick && dly_ff == 8'h01) begin
                    nxt_state = ACISC_CONV;
                end
            end
            ACISC_CONV: begin
                if (final_done && !start_ff) begin
                    nxt_state = ACISC_IDLE;
                end else if (final_done && !ctrl_ff[`ACISC_CTRL_CONT]) begin
                    nxt_state = ACISC_IDLE;
                end
            end
            default: nxt_state = ACISC_IDLE;
        endcase
        if (!ctrl_ff[`ACISC_CTRL_ENABLE]) begin
            nxt_state = ACISC_IDLE;
        end
    end
    // power-down freezes counters, marks result invalid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= ACISC_IDLE;
            presc_ff  <= 8'h00;
            cyc_ff    <= 8'h00;
            nsamp_ff  <= 7'h00;
            dly_ff    <= 8'h00;
            acc_ff    <= 16'h0000;
            halted_ff <= 1'b0;
        end else begin
            if (power_down && active) begin
                halted_ff <= 1'b1;
            end else if (final_done) begin
                halted_ff <= 1'b0;
            end
            if (!power_down) begin
                state_ff <= nxt_state;
                presc_ff <= (!active || clk_tick) ? 8'h00 : presc_ff + 8'h01;
                if (state_ff == ACISC_IDLE) begin
                    dly_ff <= 8'({initial_delay_ff, 4'h0});
                    cyc_ff <= 8'h00;
                    nsamp_ff <= 7'h00;
                    acc_ff <= 16'h0000;
                end else if (state_ff == ACISC_DELAY && clk_tick) begin
                    dly_ff <= dly_ff - 8'h01;
                end else if (samp_end) begin
                    cyc_ff <= 8'h00;
                    nsamp_ff <= final_done ? 7'h00 : nsamp_ff + 7'h01;
                    acc_ff <= final_done ? 16'h0000 : acc_ff;
                end else if (state_ff == ACISC_CONV && clk_tick) begin
                    cyc_ff <= cyc_ff + 8'h01;
                end
                if (sample_req) begin
                    acc_ff <= acc_ff + {6'h00, sample_eff};
                end
            end
        end
    end
    // result register and completion pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff  <= 16'h0000;
            invalid_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            done_ff <= final_done;
            if (final_done) begin
                result_ff  <= acc_ff;
                invalid_ff <= halted_ff;
            end
        end
    end
    acisc_window u_window (
        .pclk    (pclk),
        .presetn (presetn),
        .check   (final_done),
        .mode    (acisc_winmode_type'(winmode_ff)),
        .result  (acc_ff),
        .lo_thr  (winlo_ff),
        .hi_thr  (winhi_ff),
        .hit     (win_hit)
    );
    // set wins over read or write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 2'b00;
        end else begin
            if (done_ff) begin
                flag_ff[`ACISC_FLAG_RESULT_READY_FLAG] <= 1'b1;
            end else if (rd_result || (wr_en &&
                         paddr == `ACISC_INTFLAG_OFF && pwdata[0])) begin
                flag_ff[`ACISC_FLAG_RESULT_READY_FLAG] <= 1'b0;
            end
            if (win_hit) begin
                flag_ff[`ACISC_FLAG_WIN] <= 1'b1;
            end else if (wr_en && paddr == `ACISC_INTFLAG_OFF && pwdata[1])
            begin
                flag_ff[`ACISC_FLAG_WIN] <= 1'b0;
            end
        end
    end
    // read mux
    always_comb begin
        case (paddr)
            `ACISC_CTRL_OFF:    nxt_prdata = {24'h0, ctrl_ff};
            `ACISC_ACCUM_OFF:   nxt_prdata = {29'h0, accnum_ff};
            `ACISC_REFCFG_OFF:  nxt_prdata = {24'h0, refcfg_ff};
            `ACISC_DELAY_OFF:   nxt_prdata = {24'h0, initial_delay_ff, 1'b0,
                                              sampdly_ff};
            `ACISC_WINMODE_OFF: nxt_prdata = {29'h0, winmode_ff};
            `ACISC_SAMPLE_LENGTH_OFF: nxt_prdata = {27'h0, sample_length_ff};
            `ACISC_INSEL_OFF:   nxt_prdata = {27'h0, insel_ff};
            `ACISC_COMMAND_OFF: nxt_prdata = {31'h0, start_ff};
            `ACISC_EVCTRL_OFF:  nxt_prdata = {31'h0, evstart_ff};
            `ACISC_INTEN_OFF:   nxt_prdata = {30'h0, inten_ff};
            `ACISC_INTFLAG_OFF: nxt_prdata = {30'h0, flag_ff};
            `ACISC_RESULT_OFF:  nxt_prdata = {16'h0, result_ff};
            `ACISC_WINLO_OFF:   nxt_prdata = {16'h0, winlo_ff};
            `ACISC_WINHI_OFF:   nxt_prdata = {16'h0, winhi_ff};
            `ACISC_STATUS_OFF:  nxt_prdata = {28'h0, invalid_ff, halted_ff,
                                              state_ff};
            default:            nxt_prdata = 32'h0000_0000;
        endcase
    end
    assign prdata = rd_en ? nxt_prdata : 32'h0000_0000;
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq_result_ready_flag == (flag_ff[0] && inten_ff[0]))
        else $error("result request mismatch");
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        final_done |=> ##1 flag_ff[0])
        else $error("result ready not set");
    a_event_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !start_ff && !evstart_ff && !touch_enable &&
        !(wr_en && paddr == `ACISC_COMMAND_OFF) |=> !start_ff)
        else $error("start without enable");
    a_pd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        power_down |=> $stable(cyc_ff))
        else $error("counter moved in power down");
    a_sb_idle: assert property (@(posedge pclk) disable iff (!presetn)
        standby && !ctrl_ff[7] && state_ff == ACISC_IDLE |=>
        state_ff == ACISC_IDLE)
        else $error("started in standby");
    a_clk_req: assert property (@(posedge pclk) disable iff (!presetn)
        !active && !start_ff |-> !clock_request)
        else $error("clock requested while idle");
    a_temp_on: assert property (@(posedge pclk) disable iff (!presetn)
        channel_sel == 5'h1e |-> temp_sensor_on)
        else $error("temperature sensor off");
    a_touch_mux: assert property (@(posedge pclk) disable iff (!presetn)
        touch_enable |-> channel_sel == touch_channel)
        else $error("touch lost the channel");
endmodule

// ===== tb/acisc_analog_model.sv
/*
 analog core stand-in: answers each sample strobe with a value per channel.
 assumes sample_data is only taken in the cycle that sample_req is high.
*/
module acisc_analog_model (
    input  wire logic       pclk,        // peripheral clock
    input  wire logic       sample_req,  // sample strobe
    input  wire logic [4:0] channel_sel, // selected input
    output logic      [9:0] sample_data  // sampled value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] junk_ff = 10'h155;
    // churn outside the strobe so a late sample shows up as garbage
    always_ff @(posedge pclk) begin
        junk_ff <= ~junk_ff + 10'h001;
    end
    // value derived from channel, so a wrong channel gives a wrong result
    assign sample_data = sample_req ? {channel_sel, 5'h0a} : junk_ff;
endmodule

// ===== tb/tb_adc_compare_irq_sleep_ctrl.sv
/*
 testbench: apb master tasks and directed conversion, window and event runs.
 assumes prescaler 0 and no accumulation, so a conversion is short.
*/
`include "acisc_regs.svh"
module tb_adc_compare_irq_sleep_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, event_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, sample_req, temp_sensor_on;
    logic        clock_request, irq_result_ready_flag, irq_window, touch_done;
    logic [9:0]  sample_data;
    logic [4:0]  channel_sel;
    int          err_total, compares;
    logic [4:0]  chs [3] = '{5'h01, 5'h08, 5'h1f};
    acisc_ctrl acisc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_in(event_in), .touch_enable(1'b0), .touch_start(1'b0),
        .touch_channel(5'h00), .standby(1'b0), .power_down(1'b0),
        .sample_req(sample_req), .sample_data(sample_data),
        .channel_sel(channel_sel), .temp_sensor_on(temp_sensor_on),
        .clock_request(clock_request), .irq_result_ready_flag(irq_result_ready_flag),
        .irq_window(irq_window), .touch_done(touch_done));
    acisc_analog_model acisc_analog_model_i (.pclk(pclk),
        .sample_req(sample_req), .channel_sel(channel_sel),
        .sample_data(sample_data));
    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one apb transfer; held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(q, exp);
    endtask
    // polls the flag register, bounded, reading it does not clear it
    task wait_flag();
        q = 32'h0;
        for (int n = 0; n < 100 && q[0] !== 1'b1; n++)
            apb(1'b0, `ACISC_INTFLAG_OFF, 32'h0);
        cmp(q[0], 1'b1);
    endtask
    function automatic logic win(input int m, input logic [15:0] v);
        case (m)
            1: win = v < 16'h0100;
            2: win = v > 16'h0200;
            3: win = v > 16'h0100 && v < 16'h0200;
            4: win = v < 16'h0100 || v > 16'h0200;
            default: win = 1'b0;
        endcase
    endfunction
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, event_in} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(`ACISC_CTRL_OFF, 32'h0);
        apb(1'b1, 12'h0fc, 32'hffff_ffff);
        chk(12'h0fc, 32'h0);
        // software conversion on channel 3
        apb(1'b1, `ACISC_INSEL_OFF, 32'h3);
        apb(1'b1, `ACISC_CTRL_OFF, 32'h1);
        apb(1'b1, `ACISC_COMMAND_OFF, 32'h1);
        chk(`ACISC_COMMAND_OFF, 32'h1); // start bit held
        cmp(clock_request, 1'b1); // clock while busy
        wait_flag(); // flag on completion
        chk(`ACISC_COMMAND_OFF, 32'h0); // start bit cleared
        cmp(irq_result_ready_flag, 1'b0); // masked request
        chk(`ACISC_RESULT_OFF, 32'h6a); // result shown
        chk(`ACISC_INTFLAG_OFF, 32'h0); // read clears flag
        // window modes over three results
        apb(1'b1, `ACISC_WINLO_OFF, 32'h100);
        apb(1'b1, `ACISC_WINHI_OFF, 32'h200);
        apb(1'b1, `ACISC_INTEN_OFF, 32'h3);
        for (int m = 0; m < 5; m++) begin
            foreach (chs[i]) begin
                apb(1'b1, `ACISC_WINMODE_OFF, m);
                apb(1'b1, `ACISC_INSEL_OFF, chs[i]);
                apb(1'b1, `ACISC_COMMAND_OFF, 32'h1);
                wait_flag();
                cmp(q[1], win(m, {chs[i], 5'h0a})); // mode
                cmp(irq_window, win(m, {chs[i], 5'h0a})); // request
                cmp(irq_result_ready_flag, 1'b1); // enabled request
                apb(1'b1, `ACISC_INTFLAG_OFF, 32'h3);
                // flag clears on the access edge; look once it settles
                @(negedge pclk);
                cmp(irq_window, 1'b0); // write one clears
            end
        end
        // event start, first with the enable off
        apb(1'b1, `ACISC_WINMODE_OFF, 32'h0);
        event_in <= 1'b1;
        repeat (60) @(posedge pclk);
        event_in <= 1'b0;
        chk(`ACISC_INTFLAG_OFF, 32'h0); // ignored when off
        apb(1'b1, `ACISC_EVCTRL_OFF, 32'h1);
        event_in <= 1'b1;
        wait_flag(); // event starts
        event_in <= 1'b0;
        apb(1'b1, `ACISC_EVCTRL_OFF, 32'h0);
        apb(1'b1, `ACISC_INTFLAG_OFF, 32'h3);
        // continuous mode relaunches without a new start
        apb(1'b1, `ACISC_CTRL_OFF, 32'h3);
        apb(1'b1, `ACISC_COMMAND_OFF, 32'h1);
        wait_flag(); // first completion
        apb(1'b1, `ACISC_INTFLAG_OFF, 32'h1);
        wait_flag(); // second completion
        apb(1'b1, `ACISC_CTRL_OFF, 32'h1);
        // temperature setup: reference 0, small cap, long delays
        apb(1'b1, `ACISC_REFCFG_OFF, 32'h40); // reference and cap
        apb(1'b1, `ACISC_DELAY_OFF, 32'he0); // initial delay
        apb(1'b1, `ACISC_SAMPLE_LENGTH_OFF, 32'h1f); // sample length
        chk(`ACISC_REFCFG_OFF, 32'h40); // setup kept
        // temperature channel powers the sensor
        apb(1'b1, `ACISC_INSEL_OFF, `ACISC_TEMP_CHANNEL);
        @(negedge pclk);
        cmp(temp_sensor_on, 1'b1); // sensor on
        apb(1'b1, `ACISC_INSEL_OFF, 32'h3);
        @(negedge pclk);
        cmp(temp_sensor_on, 1'b0); // sensor off
        cmp(pslverr, 1'b0); // no bus error
        cmp(touch_done, 1'b0); // no touch completion
        conclude();
    end
endmodule
